// [design/lcdsm_ctrl.sv]
// Purpose: LCD segment memory access, freeze, bias and pin selection
// Assumes: SFR bus with one-cycle write strobe, battery mode as input
// Notes: Display output lags memory by one cycle when not frozen
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Byte holds even segment low, odd high
// - Clear bit or power-on zeroes memory
// - Pointer write selects byte, starts transfer
// - Pointer top bit set: data to memory
// - Pointer top bit clear: memory to data
// - Freeze holds old pattern until cleared
// - Ladder select resets zero, pump default
// - External ladder: no pump, bias ignored
// - Pump off while display is disabled
// - Six-bit bias level, 64 steps
// - Battery mode: on only if enabled, not off
// - Display off keeps config and memory
// - Segments 0-15 and 26 fixed, 16-25 per enable
// - Four-way mux turns 27, 28 into commons
module lcdsm_ctrl (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  output logic [7:0] sfr_rdata,
  input wire logic battery_low_power_mode,
  output logic [119:0] seg_pattern,
  output logic display_on,
  output logic pump_enable,
  output logic [5:0] bias_level_out,
  output logic [28:0] segment_line_en,
  output logic [1:0] common_line_shared
);
  lcdsm_pkg::lcdsm_regs_t s_r; // Registered state
  lcdsm_pkg::lcdsm_regs_t s_nxt; // Next state
  logic [14:0][7:0] mem_bytes; // Live memory view
  logic [119:0] mem_flat; // Memory from store
  logic [7:0] mem_rdata; // Addressed byte
  logic ptr_wr; // Pointer written this cycle
  logic mem_wr; // Data to memory
  logic mem_clr; // Clear memory
  logic [3:0] ptr_idx; // Addressed byte index
  logic [1:0] mux_lvl; // Multiplex level
  logic ext_ladder; // External ladder chosen
  logic enable_bit; // Display enable
  logic batt_off; // Off in battery mode

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  assign ptr_wr = sfr_we && hit(sfr_addr, lcdsm_pkg::ADDR_PTR);
  // Pointer bits 6:4 are don't-care; only the index nibble selects a byte
  assign ptr_idx = sfr_wdata[lcdsm_pkg::PTR_ADDR_W-1:0];
  assign mem_wr = ptr_wr && sfr_wdata[lcdsm_pkg::PTR_WRITE_BIT];
  // Clear fires on a write with the clear bit set
  assign mem_clr = sfr_we && hit(sfr_addr, lcdsm_pkg::ADDR_MAIN_CFG)
                   && sfr_wdata[lcdsm_pkg::MAIN_CLEAR_BIT];
  assign mem_bytes = mem_flat;
  // Configuration fields pulled out of the stored registers
  assign mux_lvl = s_r.main_cfg[lcdsm_pkg::MAIN_MUX_LSB +: 2];
  assign ext_ladder = s_r.volt_cfg[lcdsm_pkg::VOLT_EXT_BIT];
  assign enable_bit = s_r.main_cfg[lcdsm_pkg::MAIN_ENABLE_BIT];
  assign batt_off = s_r.main_cfg[lcdsm_pkg::MAIN_BATT_OFF_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Segment memory; the data register is the only write source
  // Store takes the data register as held, so software must load it first
  lcdsm_seg_mem u_mem (
    .clk(clk),
    .nrst(nrst),
    .clear(mem_clr),
    .wr_en(mem_wr),
    .addr(ptr_idx),
    .wdata(s_r.dat),
    .rdata(mem_rdata),
    .mem_flat(mem_flat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and transfers
  always_comb begin
    s_nxt = s_r;
    if (sfr_we) begin
      unique case (sfr_addr)
        // Clear bit never stays set
        lcdsm_pkg::ADDR_MAIN_CFG: begin
          s_nxt.main_cfg = sfr_wdata & ~(8'h01 << lcdsm_pkg::MAIN_CLEAR_BIT);
        end
        // Enables for pins 16 to 23
        lcdsm_pkg::ADDR_SEG_EN_LO: begin
          s_nxt.seg_en_lo = sfr_wdata;
        end
        // Ladder select and bias level share one register
        lcdsm_pkg::ADDR_VOLT_CFG: begin
          s_nxt.volt_cfg = sfr_wdata;
        end
        lcdsm_pkg::ADDR_PTR: begin
          s_nxt.ptr = sfr_wdata;
          // Read transfer; byte past the end gives zero
          if (!sfr_wdata[lcdsm_pkg::PTR_WRITE_BIT]) begin
            s_nxt.dat = mem_rdata;
          end
        end
        // Data register, source of the next pointer write
        lcdsm_pkg::ADDR_DAT: begin
          s_nxt.dat = sfr_wdata;
        end
        // Freeze control for glitch-free updates
        lcdsm_pkg::ADDR_UPD: begin
          s_nxt.upd = sfr_wdata;
        end
        // Enables for pins 24 and 25; upper bits are plain storage
        lcdsm_pkg::ADDR_SEG_EN_HI: begin
          s_nxt.seg_en_hi = sfr_wdata;
        end
        // Other SFRs belong elsewhere
        default: begin
          s_nxt = s_r;
        end
      endcase
    end
    // Freeze holds the shown copy; writes to memory stay invisible
    if (!s_r.upd[lcdsm_pkg::UPD_FREEZE_BIT]) begin
      s_nxt.shown = mem_bytes;
    end
  end

  // State register; display off touches none of it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; reads have no side effects
  always_comb begin
    unique case (sfr_addr)
      lcdsm_pkg::ADDR_MAIN_CFG: sfr_rdata = s_r.main_cfg;
      lcdsm_pkg::ADDR_SEG_EN_LO: sfr_rdata = s_r.seg_en_lo;
      lcdsm_pkg::ADDR_VOLT_CFG: sfr_rdata = s_r.volt_cfg;
      lcdsm_pkg::ADDR_PTR: sfr_rdata = s_r.ptr;
      lcdsm_pkg::ADDR_DAT: sfr_rdata = s_r.dat;
      lcdsm_pkg::ADDR_UPD: sfr_rdata = s_r.upd;
      lcdsm_pkg::ADDR_SEG_EN_HI: sfr_rdata = s_r.seg_en_hi;
      // Unmapped addresses read zero so other SFRs can share the bus
      default: sfr_rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Panel side
  // Byte n low nibble is segment 2n, high nibble 2n+1, bit = common
  assign seg_pattern = s_r.shown;
  // Battery mode needs enable set and battery-off clear
  assign display_on = battery_low_power_mode ? (enable_bit && !batt_off)
                                             : enable_bit;
  // Pump runs only while shown and not on ladder
  assign pump_enable = display_on && !ext_ladder;
  // Bias meaningless on ladder, forced to zero
  assign bias_level_out = ext_ladder ? 6'h00
                                     : s_r.volt_cfg[lcdsm_pkg::BIAS_W-1:0];

  // Pin function per segment line
  genvar g;
  generate
    // Lines 0 to 15 are always segments
    for (g = 0; g < lcdsm_pkg::SEG_FIXED; g++) begin : g_fixed
      assign segment_line_en[g] = 1'b1;
    end
    // Low enable byte covers lines 16 to 23, bit n on line 16+n
    for (g = 0; g < 8; g++) begin : g_lo
      assign segment_line_en[lcdsm_pkg::SEG_FIXED + g] = s_r.seg_en_lo[g];
    end
    // High enable byte drives two lines; the rest is storage only
    for (g = 0; g < lcdsm_pkg::SEG_SHARED_HI; g++) begin : g_hi
      assign segment_line_en[24 + g] = s_r.seg_en_hi[g];
    end
  endgenerate
  assign segment_line_en[26] = 1'b1;
  // 4x takes 27 for common 3; 3x or 4x takes 28 for common 2
  assign segment_line_en[27] = (mux_lvl != lcdsm_pkg::MUX_4X);
  assign segment_line_en[28] = (mux_lvl < lcdsm_pkg::MUX_3X);
  assign common_line_shared = {!segment_line_en[27], !segment_line_en[28]};

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_ptr_write_mem: assert property (@(posedge clk) disable iff (!nrst)
    (mem_wr && ptr_idx <= lcdsm_pkg::MEM_LAST && !mem_clr)
    |=> mem_bytes[$past(ptr_idx)] == $past(s_r.dat))
    else $error("pointer write did not store data");
  chk_ptr_read_dat: assert property (@(posedge clk) disable iff (!nrst)
    (ptr_wr && !sfr_wdata[7] && ptr_idx <= lcdsm_pkg::MEM_LAST)
    |=> s_r.dat == $past(mem_bytes[ptr_idx]))
    else $error("pointer read did not load data");
  chk_oob_read_zero: assert property (@(posedge clk) disable iff (!nrst)
    (ptr_wr && !sfr_wdata[7] && ptr_idx > lcdsm_pkg::MEM_LAST) |=> s_r.dat == 8'h00)
    else $error("out of range read not zero");
  chk_oob_write_keep: assert property (@(posedge clk) disable iff (!nrst)
    (mem_wr && ptr_idx > lcdsm_pkg::MEM_LAST) |=> $stable(mem_flat))
    else $error("out of range write changed memory");
  chk_clear_mem: assert property (@(posedge clk) disable iff (!nrst)
    mem_clr |=> mem_flat == '0)
    else $error("memory not cleared");
  chk_freeze_hold: assert property (@(posedge clk) disable iff (!nrst)
    s_r.upd[0] |=> $stable(seg_pattern))
    else $error("frozen pattern changed");
  chk_unfreeze_show: assert property (@(posedge clk) disable iff (!nrst)
    !s_r.upd[0] |=> seg_pattern == $past(mem_flat))
    else $error("pattern not following memory");
  chk_ladder_pump: assert property (@(posedge clk) disable iff (!nrst)
    ext_ladder |-> !pump_enable && bias_level_out == 6'h00)
    else $error("pump or bias active on ladder");
  chk_pump_off: assert property (@(posedge clk) disable iff (!nrst)
    !enable_bit |-> !pump_enable && !display_on)
    else $error("pump on with display disabled");
  chk_batt_off: assert property (@(posedge clk) disable iff (!nrst)
    (battery_low_power_mode && batt_off) |-> !display_on)
    else $error("display on in battery off");
  chk_mux4_pins: assert property (@(posedge clk) disable iff (!nrst)
    mux_lvl == 2'h3 |-> segment_line_en[28:27] == 2'b00 && common_line_shared == 2'b11)
    else $error("4x mux left shared pins as segments");
  chk_fixed_segs: assert property (@(posedge clk) disable iff (!nrst)
    segment_line_en[15:0] == 16'hffff)
    else $error("fixed segment disabled");

  ////////////////////////////////////////////////////////////////////////////
  // Further checks, grouped by the logic they guard
  // Register loads
  // Pointer keeps its whole byte for readback
  chk_ptr_reg_load: assert property (@(posedge clk) disable iff (!nrst)
    ptr_wr |=> s_r.ptr == $past(sfr_wdata))
    else $error("pointer register not loaded");
  // Data register takes a direct write
  chk_dat_reg_load: assert property (@(posedge clk) disable iff (!nrst)
    (sfr_we && sfr_addr == lcdsm_pkg::ADDR_DAT) |=> s_r.dat == $past(sfr_wdata))
    else $error("data register not loaded");
  // Freeze register follows software
  chk_freeze_reg_load: assert property (@(posedge clk) disable iff (!nrst)
    (sfr_we && sfr_addr == lcdsm_pkg::ADDR_UPD) |=> s_r.upd == $past(sfr_wdata))
    else $error("update control not loaded");
  // Ladder select and bias stored as written
  chk_volt_reg_load: assert property (@(posedge clk) disable iff (!nrst)
    (sfr_we && sfr_addr == lcdsm_pkg::ADDR_VOLT_CFG) |=> s_r.volt_cfg == $past(sfr_wdata))
    else $error("voltage config not loaded");
  // Clear is a pulse; a stuck bit would wipe every later write
  chk_clear_self: assert property (@(posedge clk) disable iff (!nrst)
    !s_r.main_cfg[lcdsm_pkg::MAIN_CLEAR_BIT])
    else $error("clear bit stayed set");
  // Memory transfers
  // Store direction must not disturb the data register
  chk_write_keeps_dat: assert property (@(posedge clk) disable iff (!nrst)
    mem_wr |=> $stable(s_r.dat))
    else $error("pointer write changed data register");
  // Load direction must not disturb the memory
  chk_read_keeps_mem: assert property (@(posedge clk) disable iff (!nrst)
    (ptr_wr && !sfr_wdata[lcdsm_pkg::PTR_WRITE_BIT] && !mem_clr) |=> $stable(mem_flat))
    else $error("pointer read changed memory");
  // Switching the display off keeps the memory
  chk_off_keeps_mem: assert property (@(posedge clk) disable iff (!nrst)
    ($fell(display_on) && !mem_clr && !mem_wr) |=> $stable(mem_flat))
    else $error("display off changed memory");
  // Drive control
  // Bias passes through while the pump is chosen
  chk_bias_pass: assert property (@(posedge clk) disable iff (!nrst)
    !ext_ladder |-> bias_level_out == s_r.volt_cfg[lcdsm_pkg::BIAS_W-1:0])
    else $error("bias level not passed through");
  // Pump runs whenever a shown display needs it
  chk_pump_on: assert property (@(posedge clk) disable iff (!nrst)
    (display_on && !ext_ladder) |-> pump_enable)
    else $error("pump off with display shown");
  // Battery mode with enable set and off bit clear shows the display
  chk_batt_on: assert property (@(posedge clk) disable iff (!nrst)
    (battery_low_power_mode && enable_bit && !batt_off) |-> display_on)
    else $error("display off in battery mode");
  // Outside battery mode only the enable bit counts
  chk_mains_on: assert property (@(posedge clk) disable iff (!nrst)
    !battery_low_power_mode |-> display_on == enable_bit)
    else $error("display state not following enable");
  // Pin use
  // Low enable byte lands on lines 16 to 23
  chk_seg_lo_load: assert property (@(posedge clk) disable iff (!nrst)
    (sfr_we && sfr_addr == lcdsm_pkg::ADDR_SEG_EN_LO) |=> segment_line_en[23:16] == $past(sfr_wdata))
    else $error("low segment enables wrong");
  // High enable bits land on lines 24 and 25
  chk_seg_hi_load: assert property (@(posedge clk) disable iff (!nrst)
    (sfr_we && sfr_addr == lcdsm_pkg::ADDR_SEG_EN_HI) |=> segment_line_en[25:24] == $past(sfr_wdata[1:0]))
    else $error("high segment enables wrong");
  // Three-way mux takes only line 28 for a common
  chk_mux3_pins: assert property (@(posedge clk) disable iff (!nrst)
    mux_lvl == lcdsm_pkg::MUX_3X |-> segment_line_en[28:27] == 2'b01 && common_line_shared == 2'b01)
    else $error("3x mux pin use wrong");
  // Lower mux levels leave both shared pins as segments
  chk_low_mux_pins: assert property (@(posedge clk) disable iff (!nrst)
    mux_lvl < lcdsm_pkg::MUX_3X |-> segment_line_en[28:26] == 3'b111 && common_line_shared == 2'b00)
    else $error("low mux took a shared pin");
endmodule
`default_nettype wire

// [design/lcdsm_pkg.sv]
// Purpose: Constants and types of the LCD segment memory and bias block
// Assumes: 8-bit SFR bus, one clock
// Notes: Bit positions inside the config registers are fixed here
package lcdsm_pkg;
  // SFR addresses
  localparam logic [7:0] ADDR_MAIN_CFG = 8'h95;
  localparam logic [7:0] ADDR_SEG_EN_LO = 8'h97;
  localparam logic [7:0] ADDR_VOLT_CFG = 8'h9c;
  localparam logic [7:0] ADDR_PTR = 8'hac;
  localparam logic [7:0] ADDR_DAT = 8'hae;
  localparam logic [7:0] ADDR_UPD = 8'hb1;
  localparam logic [7:0] ADDR_SEG_EN_HI = 8'hed;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  // Main config fields
  localparam int MAIN_ENABLE_BIT = 7;
  localparam int MAIN_BATT_OFF_BIT = 6;
  localparam int MAIN_CLEAR_BIT = 4;
  localparam int MAIN_MUX_LSB = 0;
  // Mux level codes
  localparam logic [1:0] MUX_3X = 2'h2;
  localparam logic [1:0] MUX_4X = 2'h3;
  // Voltage config fields
  localparam int VOLT_EXT_BIT = 6;
  localparam int BIAS_W = 6;
  // Pointer fields
  localparam int PTR_WRITE_BIT = 7;
  localparam int PTR_ADDR_W = 4;
  // Update control freeze bit
  localparam int UPD_FREEZE_BIT = 0;
  // Segment memory shape
  localparam int MEM_BYTES = 15;
  localparam logic [3:0] MEM_LAST = 4'he;
  localparam int SEG_LINES = 29;
  localparam int SEG_FIXED = 16;
  localparam int SEG_SHARED_HI = 2;
  // Memory storage state
  typedef struct packed {
    logic [MEM_BYTES-1:0][7:0] mem;
  } lcdsm_mem_t;
  // Register state of the main block
  typedef struct packed {
    logic [7:0] main_cfg;
    logic [7:0] seg_en_lo;
    logic [7:0] volt_cfg;
    logic [7:0] ptr;
    logic [7:0] dat;
    logic [7:0] upd;
    logic [7:0] seg_en_hi;
    logic [MEM_BYTES-1:0][7:0] shown;
  } lcdsm_regs_t;
endpackage

// [design/lcdsm_seg_mem.sv]
// Purpose: 15-byte segment memory in flip-flops
// Assumes: one write per cycle, clear has priority
// Notes: Out-of-range addresses are ignored and read as zero
`timescale 1ns/10ps
`default_nettype none
module lcdsm_seg_mem (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clear,
  input wire logic wr_en,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic [119:0] mem_flat
);
  lcdsm_pkg::lcdsm_mem_t s_r; // Stored bytes
  lcdsm_pkg::lcdsm_mem_t s_nxt; // Next bytes
  logic in_range; // Address hits an implemented byte

  assign in_range = (addr <= lcdsm_pkg::MEM_LAST);
  // Unimplemented bytes read as zero
  assign rdata = in_range ? s_r.mem[addr] : 8'h00;
  assign mem_flat = s_r.mem;

  // Next state: clear beats write
  always_comb begin
    s_nxt = s_r;
    if (clear) begin
      s_nxt.mem = '0;
    end else if (wr_en && in_range) begin
      s_nxt.mem[addr] = wdata;
    end
  end

  // Power-on reset empties the memory
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule
`default_nettype wire

// [tb/lcdsm_glass.sv]
// Purpose: Passive glass model, shows which segment cells are dark
// Assumes: One nibble per segment line, bit i lights at common i
// Notes: A pin not in segment use never darkens its cells
`timescale 1ns/10ps
`default_nettype none
module lcdsm_glass (
  input wire logic display_on,
  input wire logic [119:0] seg_pattern,
  input wire logic [28:0] segment_line_en,
  output logic [115:0] dark
);
  ////////////////////////////////////////////////////////////////////////////////
  // Nibble s is segment s; a blank or disabled pin leaves its cells clear
  always_comb begin
    for (int s = 0; s < 29; s++) begin
      dark[4*s +: 4] = (display_on && segment_line_en[s]) ? seg_pattern[4*s +: 4] : 4'h0;
    end
  end
endmodule
`default_nettype wire

// [tb/lcdsm_tb.sv]
// Purpose: Self-checking bench for the segment memory and bias block
// Assumes: Writes taken on the rising edge, reads combinational
// Notes: Random bytes from a fixed seed, corner addresses forced
`timescale 1ns/10ps
`default_nettype none
module lcd_segment_memory_and_bias_ctrl_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_we = 1'b0;
  logic battery_low_power_mode = 1'b0;
  logic [7:0] sfr_rdata;
  logic [119:0] seg_pattern;
  logic display_on;
  logic pump_enable;
  logic [5:0] bias_level_out;
  logic [28:0] segment_line_en;
  logic [1:0] common_line_shared;
  logic [115:0] dark;
  int bad_count = 0;
  int n_checks = 0;
  logic [7:0] mdl [15]; // Expected memory image
  logic [7:0] v, lo, hi;
  logic [3:0] a;
  logic [119:0] shown;
  logic [7:0] regs [7] = '{8'h95, 8'h97, 8'h9c, 8'hac, 8'hae, 8'hb1, 8'hed};
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, design and glass
  always #5 clk = ~clk;
  lcdsm_ctrl u_lcdsm_ctrl (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_we(sfr_we), .sfr_rdata(sfr_rdata), .battery_low_power_mode(battery_low_power_mode),
    .seg_pattern(seg_pattern), .display_on(display_on), .pump_enable(pump_enable),
    .bias_level_out(bias_level_out), .segment_line_en(segment_line_en),
    .common_line_shared(common_line_shared));
  lcdsm_glass u_lcdsm_glass (.display_on(display_on), .seg_pattern(seg_pattern),
    .segment_line_en(segment_line_en), .dark(dark));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare tasks, one for register bytes, one for all other results
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_val(input logic [119:0] got, input logic [119:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One write; strobe drops a cycle later so calls never collide
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge clk);
    sfr_we = 1'b1;
    sfr_addr = ad;
    sfr_wdata = d;
    @(negedge clk);
    sfr_we = 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(negedge clk);
    sfr_addr = ad;
    #1 cmp_reg(sfr_rdata, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Expected values
  function automatic logic [119:0] pat();
    for (int i = 0; i < 15; i++) pat[8*i +: 8] = mdl[i];
  endfunction
  function automatic logic [28:0] seg_en(input logic [7:0] l, input logic [7:0] h, input logic [1:0] m);
    seg_en = {m != lcdsm_pkg::MUX_3X && m != lcdsm_pkg::MUX_4X, m != lcdsm_pkg::MUX_4X, 1'b1, h[1:0], l, 16'hffff};
  endfunction
  function automatic logic [115:0] dark_exp(input logic [28:0] en);
    for (int s = 0; s < 29; s++) dark_exp[4*s +: 4] = en[s] ? pat() >> (4*s) : 4'h0;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Closing task
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(5632));
    foreach (mdl[i]) mdl[i] = 8'h00;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    rd(8'h96, 8'h00);
    cmp_val(segment_line_en, 29'h1c00ffff);
    // Frozen update: index 15 first, then 14, then random
    wr(lcdsm_pkg::ADDR_UPD, 8'h01);
    shown = pat();
    for (int i = 0; i < 24; i++) begin
      a = (i == 0) ? 4'hf : (i == 1) ? lcdsm_pkg::MEM_LAST : 4'($urandom_range(14));
      v = 8'($urandom);
      wr(lcdsm_pkg::ADDR_DAT, v);
      wr(lcdsm_pkg::ADDR_PTR, {1'b1, 3'($urandom), a});
      if (a != 4'hf) mdl[a] = v;
    end
    cmp_val(seg_pattern, shown);
    wr(lcdsm_pkg::ADDR_UPD, 8'h00);
    repeat (2) @(negedge clk);
    cmp_val(seg_pattern, pat());
    for (int i = 0; i < 16; i++) begin
      wr(lcdsm_pkg::ADDR_PTR, 8'(i));
      rd(lcdsm_pkg::ADDR_PTR, 8'(i));
      rd(lcdsm_pkg::ADDR_DAT, (i < 15) ? mdl[i] : 8'h00);
    end
    // Every battery, enable, off combination; reference raised first
    wr(8'hf4, 8'h08);
    for (int i = 0; i < 8; i++) begin
      wr(lcdsm_pkg::ADDR_MAIN_CFG, {i[1], i[0], 6'h00});
      battery_low_power_mode = i[2];
      #1 cmp_val(display_on, i[2] ? (i[1] && !i[0]) : i[1]);
    end
    rd(lcdsm_pkg::ADDR_MAIN_CFG, 8'hc0);
    wr(lcdsm_pkg::ADDR_PTR, 8'h00);
    rd(lcdsm_pkg::ADDR_DAT, mdl[0]);
    @(negedge clk);
    battery_low_power_mode = 1'b0;
    // Bias and pump, ladder on and off
    for (int i = 0; i < 6; i++) begin
      v = (i < 2) ? {1'b0, i[0], 6'h3f} : 8'($urandom);
      wr(lcdsm_pkg::ADDR_VOLT_CFG, v);
      wr(lcdsm_pkg::ADDR_MAIN_CFG, {~i[0], 7'h00});
      #1 cmp_val(bias_level_out, v[6] ? 6'h00 : v[5:0]);
      cmp_val(pump_enable, !i[0] && !v[6]);
      rd(lcdsm_pkg::ADDR_VOLT_CFG, v);
    end
    // Pin use for each mux code, with the glass watching
    for (int m = 0; m < 4; m++) begin
      lo = 8'($urandom);
      hi = 8'($urandom);
      wr(lcdsm_pkg::ADDR_SEG_EN_LO, lo);
      wr(lcdsm_pkg::ADDR_SEG_EN_HI, hi);
      wr(lcdsm_pkg::ADDR_MAIN_CFG, 8'h80 | 8'(m));
      #1 cmp_val(segment_line_en, seg_en(lo, hi, 2'(m)));
      cmp_val(common_line_shared, {m == 3, m >= 2});
      cmp_val(dark, dark_exp(seg_en(lo, hi, 2'(m))));
    end
    // Clear pulse empties the memory and reads back low
    wr(lcdsm_pkg::ADDR_MAIN_CFG, 8'h90);
    foreach (mdl[i]) mdl[i] = 8'h00;
    rd(lcdsm_pkg::ADDR_MAIN_CFG, 8'h80);
    repeat (2) @(negedge clk);
    cmp_val(seg_pattern, pat());
    // Mid-run reset wipes a freshly stored byte
    wr(lcdsm_pkg::ADDR_DAT, 8'h5a);
    wr(lcdsm_pkg::ADDR_PTR, 8'h83);
    mdl[3] = 8'h5a;
    repeat (2) @(negedge clk);
    cmp_val(seg_pattern, pat());
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    foreach (mdl[i]) mdl[i] = 8'h00;
    rd(lcdsm_pkg::ADDR_MAIN_CFG, 8'h00);
    repeat (2) @(negedge clk);
    cmp_val(seg_pattern, pat());
    wr(lcdsm_pkg::ADDR_PTR, 8'h03);
    rd(lcdsm_pkg::ADDR_DAT, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
